// File: logic/mis_core.sv
// Instruction execution for the conjunction, call, clear, watchdog, adjust, count, jump and move group.
`timescale 1ns/10ps
module mis_core (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Decoded instruction
    input  mis_pkg::mis_instr_type                 instr,
    input  wire logic                              instr_valid,
    output logic                                   instr_ready,
    // Register port
    input  wire logic [7:0]                        reg_addr,
    input  wire logic [7:0]                        reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic [7:0]                             reg_rdata,
    // Wake-up pin
    input  wire logic                              wake_pin,
    // Core state
    output logic [mis_pkg::PC_WIDTH-1:0]           pc,
    output logic [7:0]                             acc,
    output mis_pkg::mis_flags_type                 flags,
    output logic                                   halted
);
    // Memory, stack and sequencer state.
    logic [7:0]                        mem [mis_pkg::MEM_WORDS];
    logic [mis_pkg::PC_WIDTH-1:0]      stack [mis_pkg::STACK_DEPTH];
    logic [mis_pkg::STACK_PTR_W-1:0]   stack_ptr;
    mis_pkg::mis_state_type            state;
    mis_pkg::mis_state_type            next_state;
    logic [1:0]                        phase;
    logic [1:0]                        next_phase;
    mis_pkg::mis_instr_type            cur;
    logic                              preclear_first_seen;
    logic                              preclear_second_seen;
    logic                              wake_s1;
    logic                              wake_s2;
    logic                              wake_s3;

    // Address decode, shared by the read and the write path.
    function automatic logic is_mem_addr(input logic [7:0] a);
        return a <= mis_pkg::REG_MEM_TOP;
    endfunction : is_mem_addr

    // Combinational terms.
    wire logic                         take;
    wire logic                         last;
    wire logic                         commit;
    wire logic [7:0]                   mem_rd;
    mis_pkg::mis_alu_out_type          alu_res;
    wire logic                         pcl_hit;
    wire logic                         is_branch;
    wire logic                         needs_extra;
    wire logic                         is_halt;
    wire logic                         pre_first;
    wire logic                         pre_second;
    wire logic                         pre_pair_done;
    wire logic                         wd_clear_op;
    wire logic                         wd_clear;
    wire logic [mis_pkg::WD_COUNT_W-1:0] wd_count;
    wire logic                         wd_expired;
    wire logic                         wake_level;
    wire logic                         wake;
    wire logic [mis_pkg::PC_WIDTH-1:0] pc_plus;
    wire logic [mis_pkg::PC_WIDTH-1:0] next_pc;
    wire logic                         bus_mem_wr;
    wire logic                         bus_acc_wr;
    wire logic                         bus_status_wr;
    wire logic [7:0]                   next_rdata;
    wire logic [mis_pkg::PC_WIDTH-1:0] stack_top;
    mis_pkg::mis_flags_type            next_flags;

    assign take    = instr_valid && instr_ready;
    assign last    = (phase == mis_pkg::LAST_PHASE);
    assign commit  = (state == mis_pkg::st_exec) && last;
    assign mem_rd  = mem[cur.addr];
    assign pc_plus = pc + 10'h001;

    mis_alu u_alu (
        .op        (cur.op),
        .bit_sel   (cur.bit_sel),
        .acc       (acc),
        .mem       (mem_rd),
        .imm       (cur.imm),
        .carry     (flags.carry),
        .aux_carry (flags.aux_carry_flag),
        .res       (alu_res)
    );

    mis_watchdog u_watchdog (
        .clk     (clk),
        .reset   (reset),
        .clear   (wd_clear),
        .count   (wd_count),
        .expired (wd_expired)
    );

    // A memory write that lands on the counter low byte reloads it and costs one more cycle.
    assign pcl_hit     = alu_res.write_mem && (cur.addr == mis_pkg::PCL_INDEX);
    assign is_branch   = (cur.op == mis_pkg::op_call) || (cur.op == mis_pkg::op_jump_direct);
    assign needs_extra = pcl_hit || is_branch;
    assign is_halt     = (cur.op == mis_pkg::op_power_down);

    // Pre-clear pairing: either order completes the pair.
    assign pre_first     = commit && (cur.op == mis_pkg::op_watchdog_preclear_first);
    assign pre_second    = commit && (cur.op == mis_pkg::op_watchdog_preclear_second);
    assign pre_pair_done = (pre_first && preclear_second_seen) || (pre_second && preclear_first_seen);
    assign wd_clear_op   = commit && (cur.op == mis_pkg::op_watchdog_clear);
    assign wd_clear      = wd_clear_op || pre_pair_done || (commit && is_halt);

    // Only the second and third stages are looked at, so a metastable first stage never leaks.
    assign wake_level = wake_s2 && wake_s3;
    assign wake       = wake_level || wd_expired;

    // Next program counter at the end of the instruction.
    assign next_pc = is_branch ? cur.target :
                     pcl_hit ? {pc[mis_pkg::PC_WIDTH-1:8], alu_res.result} :
                     pc_plus;

    // Sequencer: one instruction cycle is four clocks, branches and counter reloads take two.
    always_comb begin
        next_state = state;
        case (state)
            mis_pkg::st_idle: begin
                if (take) begin
                    next_state = mis_pkg::st_exec;
                end
            end
            mis_pkg::st_exec: begin
                if (last) begin
                    if (is_halt) begin
                        next_state = mis_pkg::st_halt;
                    end else if (needs_extra) begin
                        next_state = mis_pkg::st_extra;
                    end else begin
                        next_state = mis_pkg::st_idle;
                    end
                end
            end
            mis_pkg::st_extra: begin
                if (last) begin
                    next_state = mis_pkg::st_idle;
                end
            end
            mis_pkg::st_halt: begin
                if (wake) begin
                    next_state = mis_pkg::st_idle;
                end
            end
            default: begin
                next_state = mis_pkg::st_idle;
            end
        endcase
    end

    assign next_phase = (next_state != state) ? 2'h0 : phase + 2'h1;

    // Flags: every flag not named by the operation holds its value.
    always_comb begin
        next_flags = flags;
        if (commit) begin
            if (alu_res.upd_zero) begin
                next_flags.zero = (alu_res.result == 8'h00);
            end
            if (alu_res.upd_carry) begin
                next_flags.carry = alu_res.carry;
            end
            if (wd_clear_op || pre_pair_done) begin
                next_flags.timeout_flag    = 1'b0;
                next_flags.power_down_flag = 1'b0;
            end
            if (is_halt) begin
                next_flags.power_down_flag = 1'b1;
                next_flags.timeout_flag    = 1'b0;
            end
        end else if (bus_status_wr) begin
            next_flags = (flags & ~mis_pkg::STATUS_WR_MASK) | (reg_wdata[5:0] & mis_pkg::STATUS_WR_MASK);
        end
        // A watchdog expiry in the same cycle as a clear is not lost.
        if (wd_expired) begin
            next_flags.timeout_flag = 1'b1;
        end
    end

    // Register port decode; the execution write wins over a same-cycle software write.
    assign bus_mem_wr    = reg_wr && is_mem_addr(reg_addr);
    assign bus_acc_wr    = reg_wr && (reg_addr == mis_pkg::REG_ACC);
    assign bus_status_wr = reg_wr && (reg_addr == mis_pkg::REG_STATUS);
    // The stack top low byte is readable so that software can see the low byte of what the last call pushed.
    assign stack_top     = stack[stack_ptr - 2'h1];
    assign next_rdata    = !reg_rd ? 8'h00 :
                           is_mem_addr(reg_addr) ? mem[reg_addr[mis_pkg::ADDR_WIDTH-1:0]] :
                           (reg_addr == mis_pkg::REG_STATUS) ? {2'h0, flags} :
                           (reg_addr == mis_pkg::REG_ACC) ? acc :
                           (reg_addr == mis_pkg::REG_PC_LOW) ? pc[7:0] :
                           (reg_addr == mis_pkg::REG_PC_HIGH) ? {6'h00, pc[mis_pkg::PC_WIDTH-1:8]} :
                           (reg_addr == mis_pkg::REG_WD_COUNT) ? wd_count :
                           (reg_addr == mis_pkg::REG_STACK_TOP) ? stack_top[7:0] :
                           8'h00;

    // Sequencer registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            state       <= mis_pkg::st_idle;
            phase       <= 2'h0;
            instr_ready <= 1'b1;
            halted      <= 1'b0;
        end else begin
            state       <= next_state;
            phase       <= next_phase;
            instr_ready <= (next_state == mis_pkg::st_idle);
            halted      <= (next_state == mis_pkg::st_halt);
        end
    end

    // Instruction latch.
    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= '0;
        end else if (take) begin
            cur <= instr;
        end
    end

    // Wake pin synchroniser.
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            wake_s1 <= wake_pin;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end

    // Program counter and stack.
    always_ff @(posedge clk) begin
        if (reset) begin
            pc        <= mis_pkg::PC_RESET;
            stack_ptr <= '0;
        end else if (commit) begin
            pc <= next_pc;
            if (cur.op == mis_pkg::op_call) begin
                stack_ptr <= stack_ptr + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (commit && (cur.op == mis_pkg::op_call)) begin
            stack[stack_ptr] <= pc_plus;
        end
    end

    // Accumulator and flags.
    always_ff @(posedge clk) begin
        if (reset) begin
            acc   <= mis_pkg::ACC_RESET;
            flags <= mis_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
            if (commit && alu_res.write_acc) begin
                acc <= alu_res.result;
            end else if (bus_acc_wr) begin
                acc <= reg_wdata;
            end
        end
    end

    // Pre-clear memory; a full clear or power-down also ends a half-done pair.
    always_ff @(posedge clk) begin
        if (reset || pre_pair_done || wd_clear_op || (commit && is_halt)) begin
            preclear_first_seen  <= 1'b0;
            preclear_second_seen <= 1'b0;
        end else begin
            preclear_first_seen  <= preclear_first_seen || pre_first;
            preclear_second_seen <= preclear_second_seen || pre_second;
        end
    end

    // Data memory keeps its contents through reset and power-down.
    always_ff @(posedge clk) begin
        if (commit && alu_res.write_mem) begin
            mem[cur.addr] <= alu_res.result;
        end else if (bus_mem_wr) begin
            mem[reg_addr[mis_pkg::ADDR_WIDTH-1:0]] <= reg_wdata;
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule : mis_core

// File: logic/mis_pkg.sv
// Shared constants and types for the instruction execution block.
package mis_pkg;
    localparam int PC_WIDTH = 10;
    localparam int ADDR_WIDTH = 6;
    localparam int MEM_WORDS = 64;
    localparam int STACK_DEPTH = 4;
    localparam int STACK_PTR_W = 2;
    localparam int WD_PRESCALE_W = 8;
    localparam int WD_COUNT_W = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CYCLE_CLOCKS = 4;
    localparam logic [1:0] LAST_PHASE = 2'(CYCLE_CLOCKS - 1);
    localparam logic [4:0] BCD_LIMIT = 5'h09;
    localparam logic [4:0] BCD_ADJUST = 5'h06;
    localparam logic [7:0] REG_MEM_TOP = 8'h3F;
    localparam logic [7:0] REG_STATUS = 8'h40;
    localparam logic [7:0] REG_ACC = 8'h41;
    localparam logic [7:0] REG_PC_LOW = 8'h42;
    localparam logic [7:0] REG_PC_HIGH = 8'h43;
    localparam logic [7:0] REG_WD_COUNT = 8'h44;
    localparam logic [7:0] REG_STACK_TOP = 8'h45;
    localparam logic [5:0] STATUS_WR_MASK = 6'h0F;
    localparam logic [ADDR_WIDTH-1:0] PCL_INDEX = 6'h02;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 10'h000;
    localparam logic [5:0] FLAGS_RESET = 6'h00;

    typedef enum logic [4:0] {
        op_nop                   = 5'h00,
        op_conj_a_mem            = 5'h01,
        op_conj_a_imm            = 5'h02,
        op_conj_to_memory        = 5'h03,
        op_call                  = 5'h04,
        op_memory_byte_zero      = 5'h05,
        op_memory_bit_zero       = 5'h06,
        op_watchdog_clear        = 5'h07,
        op_watchdog_preclear_first  = 5'h08,
        op_watchdog_preclear_second = 5'h09,
        op_ones_complement_mem   = 5'h0A,
        op_ones_complement_to_a_reg = 5'h0B,
        op_decimal_adjust        = 5'h0C,
        op_count_down_mem        = 5'h0D,
        op_count_down_to_a_reg   = 5'h0E,
        op_count_up_mem          = 5'h0F,
        op_count_up_to_a_reg     = 5'h10,
        op_power_down            = 5'h11,
        op_jump_direct           = 5'h12,
        op_load_a_reg_from_mem   = 5'h13,
        op_store_a_reg_to_mem    = 5'h14,
        op_load_a_reg_immediate  = 5'h15
    } mis_op_type;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_exec  = 2'b01,
        st_extra = 2'b10,
        st_halt  = 2'b11
    } mis_state_type;

    typedef struct packed {
        mis_op_type                op;
        logic [ADDR_WIDTH-1:0]     addr;
        logic [7:0]                imm;
        logic [2:0]                bit_sel;
        logic [PC_WIDTH-1:0]       target;
    } mis_instr_type;

    typedef struct packed {
        logic timeout_flag;
        logic power_down_flag;
        logic overflow_flag;
        logic zero;
        logic aux_carry_flag;
        logic carry;
    } mis_flags_type;

    typedef struct packed {
        logic [7:0] result;
        logic       write_mem;
        logic       write_acc;
        logic       upd_zero;
        logic       upd_carry;
        logic       carry;
    } mis_alu_out_type;
endpackage : mis_pkg

// File: logic/mis_alu.sv
// Data path for the conjunction, complement, adjust, count and move operations.
`timescale 1ns/10ps
module mis_alu (
    // Operation
    input  mis_pkg::mis_op_type      op,
    input  wire logic [2:0]          bit_sel,
    // Operands
    input  wire logic [7:0]          acc,
    input  wire logic [7:0]          mem,
    input  wire logic [7:0]          imm,
    input  wire logic                carry,
    input  wire logic                aux_carry,
    // Result
    output mis_pkg::mis_alu_out_type res
);
    logic [4:0] low_sum;
    logic       adj_low;
    logic [4:0] high_base;
    logic       adj_high;
    logic [4:0] high_sum;
    logic [7:0] bit_mask;

    assign adj_low   = ({1'b0, acc[3:0]} > mis_pkg::BCD_LIMIT) || aux_carry;
    assign low_sum   = adj_low ? {1'b0, acc[3:0]} + mis_pkg::BCD_ADJUST : {1'b0, acc[3:0]};
    assign high_base = {1'b0, acc[7:4]} + {4'h0, low_sum[4]};
    assign adj_high  = (high_base > mis_pkg::BCD_LIMIT) || carry;
    assign high_sum  = adj_high ? high_base + mis_pkg::BCD_ADJUST : high_base;
    assign bit_mask  = ~(8'h01 << bit_sel);

    always_comb begin
        res = '0;
        case (op)
            mis_pkg::op_conj_a_mem: begin
                res = '{acc & mem, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_conj_a_imm: begin
                res = '{acc & imm, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_conj_to_memory: begin
                res = '{acc & mem, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_memory_byte_zero: begin
                res = '{8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            end
            mis_pkg::op_memory_bit_zero: begin
                res = '{mem & bit_mask, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            end
            mis_pkg::op_ones_complement_mem: begin
                res = '{~mem, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_ones_complement_to_a_reg: begin
                res = '{~mem, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_decimal_adjust: begin
                res = '{{high_sum[3:0], low_sum[3:0]}, 1'b1, 1'b0, 1'b0, 1'b1, adj_high};
            end
            mis_pkg::op_count_down_mem: begin
                res = '{mem - 8'h01, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_count_up_mem: begin
                res = '{mem + 8'h01, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_count_down_to_a_reg: begin
                res = '{mem - 8'h01, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_count_up_to_a_reg: begin
                res = '{mem + 8'h01, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
            end
            mis_pkg::op_load_a_reg_from_mem: begin
                res = '{mem, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            end
            mis_pkg::op_load_a_reg_immediate: begin
                res = '{imm, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            end
            mis_pkg::op_store_a_reg_to_mem: begin
                res = '{acc, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            end
            default: begin
                res = '0;
            end
        endcase
    end
endmodule : mis_alu

// File: logic/mis_watchdog.sv
// Watchdog counter with its prescaler and a synchronous clear.
`timescale 1ns/10ps
module mis_watchdog (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Control
    input  wire logic                              clear,
    // State
    output logic [mis_pkg::WD_COUNT_W-1:0]         count,
    output logic                                   expired
);
    logic [mis_pkg::WD_PRESCALE_W-1:0] prescale;
    logic                              tick;
    logic                              wrap;

    assign tick = &prescale;
    assign wrap = tick && (&count);

    always_ff @(posedge clk) begin
        if (reset || clear) begin
            prescale <= '0;
            count    <= '0;
            expired  <= 1'b0;
        end else begin
            prescale <= prescale + 1'b1;
            count    <= tick ? count + 1'b1 : count;
            expired  <= wrap;
        end
    end
endmodule : mis_watchdog

// File: verification/mis_core_assertions.sv
// Concurrent checks tying the core's results to the instruction it took.
`timescale 1ns/10ps
module mis_core_checker (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         reset,
    // Instruction handshake
    input mis_pkg::mis_instr_type            instr,
    input wire logic                         instr_valid,
    input wire logic                         instr_ready,
    // Core state
    input wire logic [mis_pkg::PC_WIDTH-1:0] pc,
    input wire logic [7:0]                   acc,
    input mis_pkg::mis_flags_type            flags,
    input wire logic                         halted
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Results land on the fourth edge after the take and are first sampled on the fifth, so checks look five back.
    wire tk = instr_valid && instr_ready;
    a_nop_pc_step: assert property (tk && instr.op == mis_pkg::op_nop |-> ##5
        pc == $past(pc, 5) + 1'b1) else $error("nop pc");
    a_jump_target: assert property (tk && instr.op == mis_pkg::op_jump_direct |-> ##5
        pc == $past(instr.target, 5) && flags == $past(flags, 5)) else $error("jump result");
    a_call_target: assert property (tk && instr.op == mis_pkg::op_call |-> ##5
        pc == $past(instr.target, 5) && flags == $past(flags, 5)) else $error("call result");
    a_imm_move: assert property (tk && instr.op == mis_pkg::op_load_a_reg_immediate |-> ##5
        acc == $past(instr.imm, 5) && flags == $past(flags, 5)) else $error("immediate move");
    a_conj_imm: assert property (tk && instr.op == mis_pkg::op_conj_a_imm |-> ##5
        acc == ($past(acc, 5) & $past(instr.imm, 5)) && flags.zero == (acc == 8'h00)) else $error("immediate and");
    a_wd_clear: assert property (tk && instr.op == mis_pkg::op_watchdog_clear |-> ##5
        !flags.timeout_flag && !flags.power_down_flag) else $error("watchdog clear");
    a_halt_entry: assert property (tk && instr.op == mis_pkg::op_power_down |-> ##5
        halted && flags.power_down_flag && !flags.timeout_flag) else $error("power-down entry");
    a_jump_extra: assert property (tk && instr.op == mis_pkg::op_jump_direct |->
        ##1 !instr_ready [*8] ##1 instr_ready) else $error("jump length");
    c_call: cover property (tk && instr.op == mis_pkg::op_call);
    c_adjust: cover property (tk && instr.op == mis_pkg::op_decimal_adjust);
    c_wake: cover property (halted ##1 !halted);
endmodule : mis_core_checker

bind mis_core mis_core_checker u_mis_core_checker (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .pc(pc), .acc(acc), .flags(flags), .halted(halted));

// File: verification/mis_core_tb_top.sv
// Bench running every instruction against a reference model.
`timescale 1ns/10ps
module mis_core_tb_top;
    logic                   clk = 0, reset = 1, instr_valid = 0, instr_ready, halted, reg_wr = 0, reg_rd = 0;
    logic                   wake_pin = 0;
    logic [7:0]             reg_addr = 0, reg_wdata = 0, reg_rdata, acc, a, m, x, r;
    logic [9:0]             pc, t;
    logic [5:0]             ad, m_fl = 0;
    logic [4:0]             lo, hi;
    logic [31:0]            rnd = 32'h1B52;
    mis_pkg::mis_instr_type instr = '0;
    mis_pkg::mis_flags_type flags;
    int                     errors = 0, comparisons = 0, m_pc = 0, m_acc = 0, op, d, zu, k, n, ret;
    mis_core u_mis_core (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid),
        .instr_ready(instr_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wake_pin(wake_pin), .pc(pc), .acc(acc), .flags(flags), .halted(halted));
    initial forever #25 clk = ~clk;
    // The run needs about a thousand clocks, so twenty thousand means a hang.
    initial begin
        #1000000;
        errors++;
        close_out();
    end
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    task automatic check(input string s, input logic [9:0] got, input int exp);
        comparisons++;
        if (got !== 10'(exp)) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", s, exp, got);
        end
    endtask : check
    task automatic wr(input logic [7:0] ra, input logic [7:0] rv);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ra;
        reg_wdata <= rv;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ra, input int exp, input string s);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ra;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(s, reg_rdata, exp);
    endtask : rd
    task automatic exec(input int code, input logic [5:0] ia, input logic [7:0] im, input logic [9:0] it);
        @(posedge clk);
        instr <= '{mis_pkg::mis_op_type'(code), ia, im, im[2:0], it};
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        n = 0;
        do @(negedge clk); while (instr_ready !== 1'b1 && halted !== 1'b1 && n++ < 20);
        if (n > 20) errors++;
        check("pc", pc, m_pc);
        check("acc", acc, m_acc);
        check("flags", flags, m_fl);
    endtask : exec
    task automatic halt_wake();
        m_pc++;
        m_fl[5:4] = 2'b01;
        exec(17, 0, 0, 0);
        check("halted", halted, 1);
        @(posedge clk);
        wake_pin <= 1'b1;
        n = 0;
        while (instr_ready !== 1'b1 && n++ < 20) @(negedge clk);
        if (n > 20) errors++;
        check("halted", halted, 0);
        @(posedge clk);
        wake_pin <= 1'b0;
    endtask : halt_wake
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        for (k = 0; k < 66; k++) begin
            op = (k % 22) inside {7, 8, 9, 17} ? 0 : k % 22;
            {t, ad, m_fl[3:0], a} = 28'(xs());
            {m, x} = 16'(xs());
            // The counter low byte sits at index two, so random traffic keeps off it.
            if (ad == 6'h02) ad = 6'h03;
            wr(8'h40, {4'h0, m_fl[3:0]});
            wr({2'h0, ad}, m);
            wr(8'h41, a);
            m_acc = a;
            r = 0;
            d = 0;
            zu = 0;
            m_pc = (m_pc + 1) % 1024;
            case (op)
                1, 3: begin r = a & m; d = (op + 1) / 2; zu = 1; end
                2: begin r = a & x; d = 1; zu = 1; end
                4, 18: begin ret = m_pc % 256; m_pc = t; end
                5: d = 2;
                6: begin r = m & ~(8'h01 << x[2:0]); d = 2; end
                10, 11: begin r = ~m; d = 12 - op; zu = 1; end
                13, 14: begin r = m - 8'h01; d = 15 - op; zu = 1; end
                15, 16: begin r = m + 8'h01; d = 17 - op; zu = 1; end
                19, 21: begin r = (op == 19) ? m : x; d = 1; end
                20: begin r = a; d = 2; end
                12: begin
                    lo = {1'b0, a[3:0]} + ((a[3:0] > 9 || m_fl[1]) ? 5'h06 : 5'h00);
                    hi = {1'b0, a[7:4]} + lo[4];
                    if (hi > 9 || m_fl[0]) {m_fl[0], hi} = {1'b1, hi + 5'h06};
                    r = {hi[3:0], lo[3:0]};
                    d = 2;
                end
                default: ;
            endcase
            if (d == 1) m_acc = r;
            if (zu == 1) m_fl[2] = (r == 8'h00);
            exec(op, ad, x, t);
            rd({2'h0, ad}, (d == 2) ? r : m, "mem");
            check("cycles", n, (op == 4 || op == 18) ? 8 : 4);
            if (op == 4) rd(8'h45, ret, "stack");
        end
        rd(8'h42, m_pc % 256, "pcl");
        wr(8'h90, 8'hA5);
        rd(8'h90, 0, "unmapped");
        // A store to the counter low byte reloads it from the accumulator and costs one more cycle.
        wr(8'h41, 8'h5A);
        m_acc = 8'h5A;
        m_pc = (m_pc & 32'h300) | 32'h5A;
        exec(20, 6'h02, 0, 0);
        check("cycles", n, 8);
        halt_wake();
        rd(8'h44, 0, "watchdog");
        m_pc++;
        exec(8, 0, 0, 0);
        m_pc++;
        m_fl[5:4] = 2'b00;
        exec(9, 0, 0, 0);
        halt_wake();
        m_pc++;
        m_fl[5:4] = 2'b00;
        exec(7, 0, 0, 0);
        rd(8'h44, 0, "watchdog");
        close_out();
    end
endmodule : mis_core_tb_top
